//--- core/clk_sleep_map.vh
`ifndef CLK_SLEEP_MAP_VH
`define CLK_SLEEP_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets (one aligned word each)
// ----------------------------------------------------------------
`define CLKDIV_OFFSET      4'h0
`define SLEEPCTL_OFFSET    4'h4
`define PWRSTAT_OFFSET     4'h8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define UNLOCK_BIT         7
`define CODE_MSB           3
`define MODE_MSB           3
`define MODE_LSB           1
`define SE_BIT             0

// ----------------------------------------------------------------
// Values, reset values and counts
// ----------------------------------------------------------------
`define UNLOCK_PATTERN     8'h80
`define CODE_RST_PLAIN     4'h0
`define CODE_RST_FUSED     4'h3
`define CODE_MAX           4'h8
`define UNLOCK_CYCLES      3'd4
`define WAKE_HALT_CYCLES   3'd4
`define DEEP_STARTUP_CK    3'd6

// ----------------------------------------------------------------
// Sleep mode codes
// ----------------------------------------------------------------
`define MODE_IDLE          3'b000
`define MODE_ADCNR         3'b001
`define MODE_PDOWN         3'b010
`define MODE_PSAVE         3'b011
`define MODE_STANDBY       3'b110

`endif

//--- core/clock_prescaler_sleep_control.v
`timescale 1ns/100ps
`include "clk_sleep_map.vh"

module clock_prescaler_sleep_control #(
  parameter ADDR_W = 12                  // APB address width
) (
  input  wire              clk,                  // 50 MHz master clock
  input  wire              rst_b,                // Async reset, active low
  input  wire              psel,                 // APB select
  input  wire              penable,              // APB access phase
  input  wire              pwrite,               // APB direction
  input  wire [ADDR_W-1:0] paddr,                // APB byte address
  input  wire [31:0]       pwdata,               // APB write data
  output reg  [31:0]       prdata,               // APB read data
  output reg               pready,               // APB ready
  output reg               pslverr,              // APB error, unmapped
  input  wire              startup_divide_fuse,  // High when fuse programmed
  input  wire              sleep_instr,          // Sleep instruction pulse
  input  wire              wake_irq,             // Enabled interrupt pending
  input  wire              reset_req,            // System reset source
  input  wire              adc_enabled,          // ADC enable state
  output reg               cpu_clk_en,           // CPU clock enable pulse
  output reg               flash_clk_en,         // Flash clock enable pulse
  output reg               io_clk_en,            // I/O clock enable pulse
  output reg               adc_clk_en,           // ADC clock enable pulse
  output reg               adc_start,            // Start ADC conversion
  output reg               sleeping,             // Device asleep or waking
  output reg               wake_isr,             // Run interrupt after wake
  output reg               reset_restart         // Restart from reset vector
);

  // ----------------------------------------------------------------
  // Sleep sequencer states
  // ----------------------------------------------------------------
  localparam [1:0] ST_RUN   = 2'b00;   // CPU executing
  localparam [1:0] ST_SLEEP = 2'b01;   // Asleep, waiting for wake
  localparam [1:0] ST_START = 2'b10;   // Oscillator start-up time
  localparam [1:0] ST_HALT  = 2'b11;   // Extra halt before resuming

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Address match for one register word
  function reg_hit;
    input [ADDR_W-1:0] addr;
    input [3:0]        offs;
    begin
      reg_hit = (addr == {{(ADDR_W-4){1'b0}}, offs});
    end
  endfunction

  // Divider terminal count; reserved codes saturate at 256
  function [7:0] period_m1;
    input [3:0] code;
    reg   [3:0] cs;
    reg   [8:0] p;
    begin
      cs = (code > `CODE_MAX) ? `CODE_MAX : code;
      p = (9'h001 << cs) - 9'h001;
      period_m1 = p[7:0];
    end
  endfunction

  // Defined sleep modes only
  function mode_valid;
    input [2:0] m;
    begin
      case (m)
        `MODE_IDLE, `MODE_ADCNR, `MODE_PDOWN,
        `MODE_PSAVE, `MODE_STANDBY: mode_valid = 1'b1;
        default:                    mode_valid = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  reg  [3:0] code_r;           // Stored divide factor code
  reg        fuse_taken_r;     // Fuse value already loaded
  reg        unlock_r;         // Divider change unlock flag
  reg  [2:0] ucnt_r;           // Unlock window countdown
  reg  [3:0] act_code_r;       // Code the divider is running
  reg  [7:0] cnt_r;            // Divider counter
  reg  [2:0] mode_r;           // Sleep mode choice field
  reg        se_r;             // Sleep enable bit
  reg  [2:0] smode_r;          // Mode latched at sleep entry
  reg  [1:0] state_r;          // Sleep sequencer state
  reg  [2:0] wcnt_r;           // Wake countdown
  wire       tick;             // One pulse per divided period
  wire       acc_wr;           // Write taking effect this edge
  wire       wr_div;           // Write to divider control
  wire [7:0] wb;               // Low byte of write data
  wire       deep;             // Latched mode has start-up delay
  wire       io_run;           // I/O domain clock allowed
  wire       adc_run;          // ADC domain clock allowed
  reg  [7:0] rd_nxt;           // Read mux

  assign wb     = pwdata[7:0];
  assign acc_wr = psel & penable & pwrite & pready;
  assign wr_div = acc_wr & reg_hit(paddr, `CLKDIV_OFFSET);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Ready from a flop: high in the first access cycle, no wait states
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      if (psel & ~penable) begin
        // Unmapped address answers with error and zero data
        pslverr <= ~(reg_hit(paddr, `CLKDIV_OFFSET) |
                     reg_hit(paddr, `SLEEPCTL_OFFSET) |
                     reg_hit(paddr, `PWRSTAT_OFFSET));
        prdata  <= {24'h00_0000, rd_nxt};
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Read data captured in the setup cycle
  always @* begin
    rd_nxt = 8'h00;
    if (reg_hit(paddr, `CLKDIV_OFFSET)) begin
      rd_nxt = {unlock_r, 3'b000, code_r};
    end else if (reg_hit(paddr, `SLEEPCTL_OFFSET)) begin
      rd_nxt = {4'h0, mode_r, se_r};
    end else if (reg_hit(paddr, `PWRSTAT_OFFSET)) begin
      rd_nxt = {3'b000, smode_r, state_r};
    end
  end

  // ----------------------------------------------------------------
  // Divider change unlock
  // ----------------------------------------------------------------
  // Window counted in master clock cycles
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      unlock_r <= 1'b0;
      ucnt_r   <= 3'd0;
    end else if (unlock_r) begin
      if (wr_div & ~wb[`UNLOCK_BIT]) begin
        unlock_r <= 1'b0;
      end else if (ucnt_r == 3'd1) begin
        unlock_r <= 1'b0;
      end else begin
        // Rewrite of the pattern falls here: no restart
        ucnt_r <= ucnt_r - 3'd1;
      end
    end else if (wr_div & (wb == `UNLOCK_PATTERN)) begin
      unlock_r <= 1'b1;
      ucnt_r   <= `UNLOCK_CYCLES;
    end
  end

  // ----------------------------------------------------------------
  // Divide factor code
  // ----------------------------------------------------------------
  // Fuse sampled on the first edge after reset release,
  // since an async reset may only load a constant
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      code_r       <= `CODE_RST_PLAIN;
      fuse_taken_r <= 1'b0;
    end else if (!fuse_taken_r) begin
      fuse_taken_r <= 1'b1;
      code_r <= startup_divide_fuse ? `CODE_RST_FUSED
                                    : `CODE_RST_PLAIN;
    end else if (wr_div & ~wb[`UNLOCK_BIT] & unlock_r) begin
      // No range check against the fuse setting
      code_r <= wb[`CODE_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // Clock divider
  // ----------------------------------------------------------------
  assign tick = (cnt_r == period_m1(act_code_r));

  // New factor adopted only at a period boundary, so no short phase
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r      <= 8'h00;
      act_code_r <= `CODE_RST_PLAIN;
    end else if (tick) begin
      cnt_r      <= 8'h00;
      act_code_r <= code_r;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Sleep control register
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= `MODE_IDLE;
      se_r   <= 1'b0;
    end else if (acc_wr & reg_hit(paddr, `SLEEPCTL_OFFSET)) begin
      mode_r <= wb[`MODE_MSB:`MODE_LSB];
      se_r   <= wb[`SE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------
  // Deep modes stop the oscillator path and need start-up time
  assign deep = (smode_r == `MODE_PDOWN) | (smode_r == `MODE_PSAVE) |
                (smode_r == `MODE_STANDBY);

  // Entry, wake, halt and reset restart
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r       <= ST_RUN;
      smode_r       <= `MODE_IDLE;
      wcnt_r        <= 3'd0;
      adc_start     <= 1'b0;
      wake_isr      <= 1'b0;
      reset_restart <= 1'b0;
      sleeping      <= 1'b0;
    end else begin
      adc_start     <= 1'b0;
      wake_isr      <= 1'b0;
      reset_restart <= 1'b0;
      case (state_r)
        ST_RUN: begin
          // Reserved mode codes do not put the device to sleep
          if (sleep_instr & se_r & mode_valid(mode_r)) begin
            state_r  <= ST_SLEEP;
            smode_r  <= mode_r;
            sleeping <= 1'b1;
            adc_start <= adc_enabled &
                         ((mode_r == `MODE_IDLE) |
                          (mode_r == `MODE_ADCNR));
          end
        end
        ST_SLEEP: begin
          if (reset_req) begin
            state_r       <= ST_RUN;
            sleeping      <= 1'b0;
            reset_restart <= 1'b1;
          end else if (wake_irq) begin
            if (deep) begin
              state_r <= ST_START;
              wcnt_r  <= `DEEP_STARTUP_CK;
            end else begin
              state_r <= ST_HALT;
              wcnt_r  <= `WAKE_HALT_CYCLES;
            end
          end
        end
        ST_START: begin
          if (reset_req) begin
            state_r       <= ST_RUN;
            sleeping      <= 1'b0;
            reset_restart <= 1'b1;
          end else if (wcnt_r == 3'd1) begin
            state_r <= ST_HALT;
            wcnt_r  <= `WAKE_HALT_CYCLES;
          end else begin
            wcnt_r <= wcnt_r - 3'd1;
          end
        end
        ST_HALT: begin
          // Halt counted in divided CPU cycles
          if (reset_req) begin
            state_r       <= ST_RUN;
            sleeping      <= 1'b0;
            reset_restart <= 1'b1;
          end else if (tick & (wcnt_r == 3'd1)) begin
            state_r  <= ST_RUN;
            sleeping <= 1'b0;
            wake_isr <= 1'b1;
          end else if (tick) begin
            wcnt_r <= wcnt_r - 3'd1;
          end
        end
        default: begin
          state_r  <= ST_RUN;
          sleeping <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock domain gating
  // ----------------------------------------------------------------
  // Idle keeps I/O and ADC running; ADC noise mode keeps ADC only
  assign io_run  = (state_r != ST_SLEEP) |
                   (smode_r == `MODE_IDLE);
  assign adc_run = io_run | (smode_r == `MODE_ADCNR);

  // Enables registered so each output comes from a flop.
  // Gating only stops enables; CPU state is never reset here.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_clk_en   <= 1'b0;
      flash_clk_en <= 1'b0;
      io_clk_en    <= 1'b0;
      adc_clk_en   <= 1'b0;
    end else begin
      cpu_clk_en   <= tick & (state_r == ST_RUN);
      flash_clk_en <= tick & (state_r == ST_RUN);
      io_clk_en    <= tick & io_run;
      adc_clk_en   <= tick & adc_run;
    end
  end

endmodule

//--- tb/clock_prescaler_sleep_control_properties.sv
`timescale 1ns/100ps
`include "clk_sleep_map.vh"

module clock_prescaler_sleep_props #(
  parameter ADDR_W = 12
) (
  input wire              clk,
  input wire              rst_b,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              sleep_instr,
  input wire              reset_req,
  input wire              adc_enabled,
  input wire              cpu_clk_en,
  input wire              flash_clk_en,
  input wire              adc_start,
  input wire              sleeping,
  input wire              wake_isr,
  input wire              reset_restart
);
  // ----------------------------------------------------------------
  // One clock domain, so one default for all properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Core and flash share one divided enable
  cpu_flash_pair_a: assert property (cpu_clk_en == flash_clk_en)
    else $error("cpu and flash enables differ");
  sleep_cause_a: assert property ($rose(sleeping) |-> $past(sleep_instr))
    else $error("sleep entered without a sleep instruction");
  // One cycle of grace at entry while the last enable drains
  core_halt_a: assert property (sleeping && $past(sleeping) |-> !cpu_clk_en)
    else $error("core enable pulsed while asleep");
  adc_entry_a: assert property (adc_start |-> $rose(sleeping) && $past(adc_enabled))
    else $error("conversion start outside sleep entry");
  reset_wake_a: assert property (reset_req && sleeping |=> reset_restart && !sleeping)
    else $error("reset did not end sleep next cycle");
  vector_only_a: assert property (reset_restart |-> !wake_isr && $past(sleeping))
    else $error("restart pulse without a sleep or with resume");
  wake_halt_a: assert property (wake_isr |-> $past(sleeping) && $past(sleeping, 4))
    else $error("resume came before the halt cycles");
  upper_zero_a: assert property (psel && penable && pready && !pwrite &&
    paddr == `SLEEPCTL_OFFSET |-> prdata[7:4] == 4'h0)
    else $error("sleep control upper bits not zero");

  cover property ($rose(sleeping));
  cover property (wake_isr);
  cover property (reset_restart);
endmodule

bind clock_prescaler_sleep_control clock_prescaler_sleep_props #(.ADDR_W(ADDR_W)) u_props (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .sleep_instr(sleep_instr),
  .reset_req(reset_req), .adc_enabled(adc_enabled), .cpu_clk_en(cpu_clk_en),
  .flash_clk_en(flash_clk_en), .adc_start(adc_start), .sleeping(sleeping),
  .wake_isr(wake_isr), .reset_restart(reset_restart));

//--- tb/testbench.sv
`timescale 1ns/100ps
`include "clk_sleep_map.vh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module testbench;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, seed;
  logic        fuse = 0, sleep_instr = 0, wake_irq = 0, reset_req = 0, adc_en = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, cpu_en, flash_en, io_en, adc_ck, adc_start;
  wire         sleeping, wake_isr, reset_restart;
  int          n_errors = 0, compares = 0, cyc = 0, n;
  logic [8:0]  exp_q[$];        // Expected {pslverr, rdata} per transfer
  logic [8:0]  mon_e;
  // Standby code is used as if a crystal clocks the part
  logic [2:0]  modes [8] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd6, 3'd4, 3'd5, 3'd7};
  bit          ok;

  always #10 clk = ~clk;

  clock_prescaler_sleep_control i_dut (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .startup_divide_fuse(fuse), .sleep_instr(sleep_instr),
    .wake_irq(wake_irq), .reset_req(reset_req), .adc_enabled(adc_en),
    .cpu_clk_en(cpu_en), .flash_clk_en(flash_en), .io_clk_en(io_en),
    .adc_clk_en(adc_ck), .adc_start(adc_start), .sleeping(sleeping),
    .wake_isr(wake_isr), .reset_restart(reset_restart));

  task stop_test;
    $display("Errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard: whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      stop_test();
    end
  end

  // Monitor: each completed transfer against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
      mon_e = exp_q.pop_front();
      `CHK("apb_result", mon_e, {pslverr, pwrite ? 8'h00 : prdata[7:0]})
    end
  end

  // APB master; upper write bits random since they are ignored
  task apb(input bit w, input [11:0] a, input [7:0] d, input [8:0] e);
    logic [31:0] r;
    r = $urandom;
    r[7:0] = d;
    exp_q.push_back(e);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= r;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task wr(input [11:0] a, input [7:0] d); apb(1, a, d, 9'h000); endtask
  task rd(input [11:0] a, input [8:0] e); apb(0, a, 8'h00, e); endtask

  // Cycles from one core enable pulse to the next
  task ticks(output int k);
    do @(posedge clk); while (!cpu_en);
    k = 0;
    do begin @(posedge clk); k++; end while (!cpu_en && k < 600);
  endtask

  task rst(input bit f);
    @(posedge clk) rst_b <= 0;
    fuse <= f;
    repeat (2) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
  endtask

  task pulse_sleep;
    @(posedge clk) sleep_instr <= 1;
    @(posedge clk) sleep_instr <= 0;
  endtask

  initial begin
    seed = $urandom(32'hf820);
    for (int f = 0; f < 2; f++) begin
      rst(f[0]);
      rd(`CLKDIV_OFFSET, {5'h00, f ? `CODE_RST_FUSED : `CODE_RST_PLAIN});
    end
    // Every code through the unlock, reserved ones too
    for (int c = 0; c < 16; c++) begin
      // Wake request held low across the two-write sequence
      wr(0, `UNLOCK_PATTERN);
      wr(0, c[7:0]);
      rd(0, {5'h00, c[3:0]});
      ticks(n);
      ticks(n);
      `CHK("factor", 1 << (c > 8 ? 8 : c), n)
    end
    // Open flag readable; late, refused and rewritten unlocks
    wr(0, 8'h80); rd(0, 9'h08f); wr(0, 8'h02); rd(0, 9'h00f);
    wr(0, 8'h81); wr(0, 8'h02); rd(0, 9'h00f);
    wr(0, 8'h80); wr(0, 8'h80); wr(0, 8'h02); rd(0, 9'h00f);
    wr(0, 8'h80); wr(0, 8'h00); rd(0, 9'h000);
    // Let the slow period drain so later wake counts run at divide by one
    ticks(n);
    `CHK("factor_one", 1, n)
    wr(4, 8'hff); rd(4, 9'h00f);
    rd(12'h00c, 9'h100);
    apb(1, 12'h010, 8'h55, 9'h100);
    // Enable bit clear: instruction has no effect
    wr(4, 8'h00); pulse_sleep(); repeat (3) @(posedge clk);
    `CHK("no_sleep", 1'b0, sleeping)
    foreach (modes[i]) begin
      adc_en <= 1'($urandom);
      wr(4, {4'h0, modes[i], 1'b1});
      pulse_sleep();
      @(posedge clk);
      ok = modes[i] < 4 || modes[i] == 6;
      `CHK("sleeping", ok, sleeping)
      `CHK("adc_start", ok && adc_en && modes[i] < 2, adc_start)
      if (ok) begin
        repeat (3) @(posedge clk);
        `CHK("io_run", modes[i] == 0, io_en)
        `CHK("adc_run", modes[i] < 2, adc_ck)
        // Status word shows latched mode and the sleep state
        rd(8, {4'h0, modes[i], 2'b01});
        if (modes[i] == 3) begin
          reset_req <= 1;
          @(posedge clk) reset_req <= 0;
          @(posedge clk);
          `CHK("restart", 1'b1, reset_restart)
        end else begin
          wake_irq <= 1;
          n = 0;
          do begin @(posedge clk); n++; end while (wake_isr !== 1'b1 && n < 60);
          wake_irq <= 0;
          `CHK("wake_delay", 1'b1, n >= (modes[i] > 1 ? 10 : 4) && n < 40)
          `CHK("awake", 1'b0, sleeping)
        end
      end
    end
    stop_test();
  end
endmodule
